// *** ifm_pkg.sv ***
// constants and carrier types of the input function mapper
// ----------------------------------------------------------------------------
// How it works
// - each of eight terminals has its own function code; reset defaults fixed.
// - code 0 unused; only listed codes 1-13,16-18,24-27,32-53 drive functions.
// - terminals sharing one function code are ORed together.
// - alarm clear and absolute alarm clear fire on active-to-inactive edge.
// - position preset fires on inactive-to-active edge.
// - excitation-on and configurator-unlock read active when nowhere assigned.
// - direct and remote copies of those two are ANDed when both assigned.
// - per-terminal polarity, 0 normally open, 1 inverted; default 0.
// - six data-select bits form the operation data number, bit 0 lowest.
// - remote bits are a second source of the same functions.
// ----------------------------------------------------------------------------
package ifm_pkg;

  localparam int IFM_TERMINALS = 8;
  localparam int IFM_CODE_W = 6;
  localparam int IFM_FUNCS = 64;

  // function codes
  localparam logic [5:0] IFM_FN_NONE = 6'h00;
  localparam logic [5:0] IFM_FN_HOME = 6'h03;
  localparam logic [5:0] IFM_FN_START = 6'h04;
  localparam logic [5:0] IFM_FN_DIRECT_POSITION_SELECT0 = 6'h08;
  localparam logic [5:0] IFM_FN_FREE_RUN = 6'h10;
  localparam logic [5:0] IFM_FN_EXCITE_ON = 6'h11;
  localparam logic [5:0] IFM_FN_STOP = 6'h12;
  localparam logic [5:0] IFM_FN_ALARM_CLEAR_CMD = 6'h18;
  localparam logic [5:0] IFM_FN_POSITION_PRESET = 6'h19;
  localparam logic [5:0] IFM_FN_ABS_POSITION_ALARM_CLEAR = 6'h1A;
  localparam logic [5:0] IFM_FN_CONFIGURATOR_UNLOCK = 6'h1B;
  localparam logic [5:0] IFM_FN_GENERAL_PURPOSE_BIT0 = 6'h20;
  localparam logic [5:0] IFM_FN_DATA_SELECT_BIT0 = 6'h30;
  localparam logic [5:0] IFM_FN_DATA_SELECT_BIT1 = 6'h31;
  localparam logic [5:0] IFM_FN_DATA_SELECT_BIT2 = 6'h32;

  // one bit per code that names a real function
  localparam logic [63:0] IFM_VALID_CODES = 64'h003F_FFFF_0F07_3FFE;

  // reset values, terminal 7 first
  localparam logic [7:0][5:0] IFM_FUNC_DEFAULTS = {
    IFM_FN_ALARM_CLEAR_CMD, IFM_FN_STOP, IFM_FN_FREE_RUN, IFM_FN_DATA_SELECT_BIT2,
    IFM_FN_DATA_SELECT_BIT1, IFM_FN_DATA_SELECT_BIT0, IFM_FN_START, IFM_FN_HOME};
  localparam logic [7:0] IFM_POLARITY_DEFAULT = 8'h00;

  // edge-triggered events: bit 0 alarm clear, 1 absolute clear, 2 preset
  localparam int IFM_EVENTS = 3;
  localparam logic [2:0] IFM_EVENT_RISE_MASK = 3'h4;

  typedef struct packed {
    logic [7:0][5:0] func_sel;
    logic [7:0] polarity;
  } ifm_cfg_s;

  typedef struct packed {
    logic position_preset;
    logic abs_position_alarm_clear;
    logic alarm_clear_cmd;
  } ifm_event_s;

endpackage

// *** ifm_edge_detect.sv ***
// per-bit edge pulse generator for the edge-triggered functions
`timescale 1ns/1ns
`default_nettype none
module ifm_edge_detect
  import ifm_pkg::*;
#(
  parameter int W = IFM_EVENTS,
  parameter logic [W-1:0] RISE_MASK = IFM_EVENT_RISE_MASK
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // levels in, one-cycle pulses out
  input wire logic [W-1:0] level,
  output logic [W-1:0] pulse
);

  logic [W-1:0] prev;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prev <= '0;
    end else begin
      prev <= level;
    end
  end

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        pulse[i] <= 1'b0;
      end else if (RISE_MASK[i]) begin
        pulse[i] <= level[i] & ~prev[i];
      end else begin
        pulse[i] <= prev[i] & ~level[i];
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_pulse_one_cycle: assert property (pulse[0] |=> !pulse[0])
    else $error("edge pulse held longer than one cycle");

endmodule // ifm_edge_detect
`default_nettype wire

// *** ifm_input_function_mapper.sv ***
// input function mapper: terminals and remote bits to internal driver functions
`timescale 1ns/1ns
`default_nettype none
module ifm_input_function_mapper
  import ifm_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // physical input terminals, already synchronous
  input wire logic [7:0] input_terminal,
  // configuration load
  input wire logic cfg_load,
  input wire ifm_cfg_s cfg_in,
  output ifm_cfg_s cfg_out,
  // remote copies written over the serial link
  input wire logic [63:0] remote_func,
  input wire logic remote_excite_assigned,
  input wire logic remote_unlock_assigned,
  // decoded functions
  output logic [63:0] func_level,
  output logic [5:0] data_number,
  output logic [5:0] direct_position_select,
  output logic [15:0] general_purpose,
  output logic excite_on,
  output logic configurator_unlock,
  output ifm_event_s events
);

  // --------------------------------------------------------------------------
  // configuration storage
  // --------------------------------------------------------------------------
  logic [7:0][5:0] func_sel;
  logic [7:0] polarity;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      func_sel <= IFM_FUNC_DEFAULTS;
    end else if (cfg_load) begin
      func_sel <= cfg_in.func_sel;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      polarity <= IFM_POLARITY_DEFAULT;
    end else if (cfg_load) begin
      polarity <= cfg_in.polarity;
    end
  end

  assign cfg_out.func_sel = func_sel;
  assign cfg_out.polarity = polarity;

  // --------------------------------------------------------------------------
  // terminal decoding
  // --------------------------------------------------------------------------
  logic [7:0] term_active;
  logic [63:0] direct_hit;
  logic [63:0] direct_asg;
  logic [63:0] next_level;

  assign term_active = input_terminal ^ polarity;

  always_comb begin
    direct_hit = '0;
    direct_asg = '0;
    for (int t = 0; t < IFM_TERMINALS; t++) begin
      direct_hit[func_sel[t]] = direct_hit[func_sel[t]] | term_active[t];
      direct_asg[func_sel[t]] = 1'b1;
    end
  end

  // merges direct and remote copies of an always-on-when-unassigned input
  function automatic logic merge_default_on(input logic d_hit, input logic d_asg,
                                            input logic r_bit, input logic r_asg);
    logic v;
    v = 1'b1;
    if (d_asg && r_asg) begin
      v = d_hit & r_bit;
    end else if (d_asg) begin
      v = d_hit;
    end else if (r_asg) begin
      v = r_bit;
    end
    return v;
  endfunction

  always_comb begin
    // only listed codes pass; code 0 is dropped
    next_level = (direct_hit | remote_func) & IFM_VALID_CODES;
    next_level[IFM_FN_EXCITE_ON] = merge_default_on(direct_hit[IFM_FN_EXCITE_ON],
      direct_asg[IFM_FN_EXCITE_ON], remote_func[IFM_FN_EXCITE_ON], remote_excite_assigned);
    next_level[IFM_FN_CONFIGURATOR_UNLOCK] = merge_default_on(
      direct_hit[IFM_FN_CONFIGURATOR_UNLOCK], direct_asg[IFM_FN_CONFIGURATOR_UNLOCK],
      remote_func[IFM_FN_CONFIGURATOR_UNLOCK], remote_unlock_assigned);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      func_level <= '0;
    end else begin
      func_level <= next_level;
    end
  end

  // --------------------------------------------------------------------------
  // grouped views of the function vector
  // --------------------------------------------------------------------------
  // data number, bit 0 lowest
  assign data_number = func_level[IFM_FN_DATA_SELECT_BIT0 +: 6];
  assign direct_position_select = func_level[IFM_FN_DIRECT_POSITION_SELECT0 +: 6];
  assign general_purpose = func_level[IFM_FN_GENERAL_PURPOSE_BIT0 +: 16];
  assign excite_on = func_level[IFM_FN_EXCITE_ON];
  assign configurator_unlock = func_level[IFM_FN_CONFIGURATOR_UNLOCK];

  // --------------------------------------------------------------------------
  // edge-triggered functions
  // --------------------------------------------------------------------------
  logic [2:0] event_level;
  logic [2:0] event_pulse;

  // edges are taken on the corrected, merged level so a polarity flip counts as one
  assign event_level = {func_level[IFM_FN_POSITION_PRESET],
                        func_level[IFM_FN_ABS_POSITION_ALARM_CLEAR],
                        func_level[IFM_FN_ALARM_CLEAR_CMD]};

  ifm_edge_detect #(
    .W(IFM_EVENTS),
    .RISE_MASK(IFM_EVENT_RISE_MASK)
  ) u_edges (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .level(event_level),
    .pulse(event_pulse)
  );

  assign events.alarm_clear_cmd = event_pulse[0];
  assign events.abs_position_alarm_clear = event_pulse[1];
  assign events.position_preset = event_pulse[2];

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // a fall that comes only from reset clearing the level is no command
  sequence s_alarm_fall;
    $fell(func_level[IFM_FN_ALARM_CLEAR_CMD]) && $past(rst_n);
  endsequence

  sequence s_alarm_pulse;
    events.alarm_clear_cmd ##1 !events.alarm_clear_cmd;
  endsequence

  a_reset_defaults: assert property ($past(!rst_n) |-> func_sel == IFM_FUNC_DEFAULTS
                                     && polarity == IFM_POLARITY_DEFAULT)
    else $error("configuration not at defaults after reset");

  a_unused_code: assert property ((func_level & ~IFM_VALID_CODES) == 64'h0)
    else $error("unlisted or unused code drives a function");

  a_or_merge: assert property ((term_active[0] && IFM_VALID_CODES[func_sel[0]]
      && func_sel[0] != IFM_FN_EXCITE_ON && func_sel[0] != IFM_FN_CONFIGURATOR_UNLOCK)
      |=> func_level[$past(func_sel[0])])
    else $error("active terminal did not raise its function");

  a_fall_alarm: assert property (s_alarm_fall |=> s_alarm_pulse)
    else $error("alarm clear not pulsed on falling edge");

  a_alarm_cause: assert property (events.alarm_clear_cmd
      |-> $past(func_level[IFM_FN_ALARM_CLEAR_CMD], 2)
      && !$past(func_level[IFM_FN_ALARM_CLEAR_CMD]))
    else $error("alarm clear pulsed without falling edge");

  a_rise_preset: assert property ($rose(func_level[IFM_FN_POSITION_PRESET])
      |=> events.position_preset)
    else $error("preset not pulsed on rising edge");

  a_preset_cause: assert property (events.position_preset
      |-> $past(func_level[IFM_FN_POSITION_PRESET])
      && !$past(func_level[IFM_FN_POSITION_PRESET], 2))
    else $error("preset pulsed without rising edge");

  a_abs_fall: assert property ($fell(func_level[IFM_FN_ABS_POSITION_ALARM_CLEAR])
      && $past(rst_n) |=> events.abs_position_alarm_clear)
    else $error("absolute alarm clear not pulsed on falling edge");

  a_default_on: assert property ((!direct_asg[IFM_FN_EXCITE_ON] && !remote_excite_assigned)
      |=> excite_on)
    else $error("unassigned excitation-on not held active");

  a_unlock_default: assert property ((!direct_asg[IFM_FN_CONFIGURATOR_UNLOCK]
      && !remote_unlock_assigned) |=> configurator_unlock)
    else $error("unassigned configurator unlock not held active");

  a_both_and: assert property ((direct_asg[IFM_FN_CONFIGURATOR_UNLOCK] && remote_unlock_assigned
      && !(direct_hit[IFM_FN_CONFIGURATOR_UNLOCK] && remote_func[IFM_FN_CONFIGURATOR_UNLOCK]))
      |=> !configurator_unlock)
    else $error("unlock active without both copies");

  a_polarity_sense: assert property ((func_sel[0] == IFM_FN_STOP
      && input_terminal[0] != polarity[0]) |=> func_level[IFM_FN_STOP])
    else $error("polarity not applied to terminal");

  a_polarity_before: assert property ((func_sel == {8{IFM_FN_STOP}} && remote_func == 64'h0
      && (input_terminal ^ polarity) == 8'h00) |=> !func_level[IFM_FN_STOP])
    else $error("inverted inactive terminal still drove function");

  a_data_number: assert property ((func_sel[2] == IFM_FN_DATA_SELECT_BIT0
      && term_active[2]) |=> data_number[0])
    else $error("data number bits misordered");

  a_remote_source: assert property (remote_func[IFM_FN_GENERAL_PURPOSE_BIT0 + 6'h05]
      |=> general_purpose[5])
    else $error("remote bit did not drive function");

endmodule // ifm_input_function_mapper
`default_nettype wire

// *** ifm_switch_model.sv ***
// switch bank model that drives the eight input terminals
`timescale 1ns/1ns
`default_nettype none
module ifm_switch_model (
  // contact commands from the bench
  input wire logic [7:0] pressed,
  // terminal levels toward the mapper
  output logic [7:0] input_terminal
);
  // ----------------------------------------
  // contacts
  // ----------------------------------------
  // an open contact is pulled down, so a released terminal reads low, never the last value
  assign input_terminal = pressed;
endmodule // ifm_switch_model
`default_nettype wire

// *** testbench.sv ***
// self-checking bench of the input function mapper
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module testbench;
  import ifm_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] pressed = 8'h00;
  logic [7:0] input_terminal;
  logic cfg_load = 1'b0;
  ifm_cfg_s cfg_in = '0;
  ifm_cfg_s cfg_out;
  ifm_cfg_s cfg_exp;
  logic [63:0] remote_func = '0;
  logic remote_excite_assigned = 1'b0;
  logic remote_unlock_assigned = 1'b0;
  logic [63:0] func_level;
  logic [5:0] data_number;
  logic [5:0] direct_position_select;
  logic [15:0] general_purpose;
  logic excite_on;
  logic configurator_unlock;
  ifm_event_s events;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;

  always #5 core_clk = ~core_clk;

  ifm_switch_model u_sw (.pressed(pressed), .input_terminal(input_terminal));

  ifm_input_function_mapper u_dut (.core_clk(core_clk), .rst_n(rst_n),
    .input_terminal(input_terminal), .cfg_load(cfg_load), .cfg_in(cfg_in), .cfg_out(cfg_out),
    .remote_func(remote_func), .remote_excite_assigned(remote_excite_assigned),
    .remote_unlock_assigned(remote_unlock_assigned), .func_level(func_level),
    .data_number(data_number), .direct_position_select(direct_position_select),
    .general_purpose(general_purpose), .excite_on(excite_on),
    .configurator_unlock(configurator_unlock), .events(events));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic give_verdict();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // the whole run needs well under 200 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 2000) begin
      miscompares++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    tick(6);
    `CHK(cfg_out, {IFM_FUNC_DEFAULTS, 8'h00})
    rst_n = 1'b1;
    tick(1);
    `CHK(func_level, 64'h0000_0000_0802_0000)
    `CHK(excite_on & configurator_unlock, 1'b1)
    $display("reset defaults done");
    pressed = 8'h1D;
    tick(1);
    `CHK(data_number, 6'h07)
    `CHK(func_level[3], 1'b1)
    pressed = 8'h80;
    tick(2);
    `CHK(events, 3'h0)
    pressed = 8'h00;
    tick(2);
    `CHK(events, 3'h1)
    tick(1);
    `CHK(events, 3'h0)
    $display("default mapping done");
    // new map: t0 preset, t1 abs clear inverted, t2/t3 shared, t4 excite, t5 unlock, t6 invalid
    cfg_exp.func_sel = {6'h00, 6'h0E, 6'h1B, 6'h11, 6'h20, 6'h20, 6'h1A, 6'h19};
    cfg_exp.polarity = 8'h42;
    cfg_in = cfg_exp;
    cfg_load = 1'b1;
    tick(1);
    cfg_load = 1'b0;
    `CHK(cfg_out, cfg_exp)
    tick(1);
    `CHK(func_level, 64'h0000_0000_0400_0000)
    pressed = 8'h01;
    tick(2);
    `CHK(events, 3'h4)
    pressed = 8'h00;
    tick(2);
    `CHK(events, 3'h0)
    pressed = 8'h02;
    tick(2);
    `CHK(events, 3'h2)
    $display("edge events done");
    // shared code on two terminals, against the advice to the configuring party
    pressed = 8'h08;
    tick(1);
    `CHK(general_purpose[0], 1'b1)
    pressed = 8'h04;
    tick(1);
    `CHK(general_purpose[0], 1'b1)
    pressed = 8'h10;
    remote_excite_assigned = 1'b1;
    tick(1);
    `CHK(excite_on, 1'b0)
    remote_func[17] = 1'b1;
    tick(1);
    `CHK(excite_on, 1'b1)
    pressed = 8'h20;
    tick(1);
    `CHK(excite_on, 1'b0)
    `CHK(configurator_unlock, 1'b1)
    remote_func[37] = 1'b1;
    remote_func[14] = 1'b1;
    remote_func[53] = 1'b1;
    remote_func[10] = 1'b1;
    tick(1);
    `CHK(general_purpose, 16'h0020)
    `CHK(func_level[14], 1'b0)
    `CHK(data_number, 6'h20)
    `CHK(direct_position_select, 6'h04)
    // unlock on terminal 5 and on the remote side: both copies must be on
    remote_unlock_assigned = 1'b1;
    tick(1);
    `CHK(configurator_unlock, 1'b0)
    remote_func[27] = 1'b1;
    tick(1);
    `CHK(configurator_unlock, 1'b1)
    $display("remote and duplicates done");
    // every terminal on stop and inverted: only an open contact is active
    cfg_in.func_sel = {8{IFM_FN_STOP}};
    cfg_in.polarity = 8'hFF;
    cfg_load = 1'b1;
    pressed = 8'hFF;
    remote_func = '0;
    remote_excite_assigned = 1'b0;
    remote_unlock_assigned = 1'b0;
    tick(1);
    cfg_load = 1'b0;
    tick(1);
    `CHK(func_level, 64'h0000_0000_0802_0000)
    pressed = 8'hFE;
    tick(1);
    `CHK(func_level[IFM_FN_STOP], 1'b1)
    $display("inverted shared map done");
    // reset in mid-run brings the defaults back
    rst_n = 1'b0;
    pressed = 8'h00;
    tick(2);
    `CHK(cfg_out, {IFM_FUNC_DEFAULTS, IFM_POLARITY_DEFAULT})
    `CHK(func_level, 64'h0)
    rst_n = 1'b1;
    tick(1);
    `CHK(func_level, 64'h0000_0000_0802_0000)
    `CHK(events, 3'h0)
    $display("mid-run reset done");
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
